// ---- rtl/sfr_bank1_decode.v ----
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sfr_bank1_regs.vh"

module sfr_bank1_decode (
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  input wire power_on_reset_in,
  input wire brown_out_reset_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire status_timeout_in,
  input wire status_power_down_in,
  input wire slave_in_full_in,
  input wire slave_out_full_in,
  input wire slave_overflow_set_in,
  input wire [5:0] serial_port_flags_in,
  input wire tx_shift_empty_in,
  output wire [8:0] mem_addr_out,
  output wire mem_rd_out,
  output wire mem_wr_out,
  output wire [7:0] mem_wdata_out,
  input wire [7:0] mem_rdata_in,
  output reg pc_load_out,
  output reg [12:0] pc_load_value_out,
  output wire [7:0] option_config_out,
  output wire [7:0] counter_low_byte_out,
  output wire indirect_bank_select_out,
  output wire [1:0] direct_bank_select_out,
  output wire [2:0] alu_flags_out,
  output wire [7:0] indirect_pointer_out,
  output wire [5:0] port_a_direction_out,
  output wire [7:0] port_b_direction_out,
  output wire [7:0] port_c_direction_out,
  output wire [7:0] port_d_direction_out,
  output wire [2:0] port_e_direction_out,
  output wire slave_port_mode_out,
  output wire slave_overflow_out,
  output wire [4:0] upper_counter_buffer_out,
  output wire [7:0] interrupt_control_out,
  output wire [7:0] peripheral_irq_enable_1_out,
  output wire peripheral_irq_enable_2_out,
  output wire [1:0] power_reset_cause_out,
  output wire [7:0] timer2_period_out,
  output wire [7:0] serial_slave_address_out,
  output wire [5:0] uart_tx_control_out,
  output wire [7:0] baud_divisor_out,
  output wire [2:0] converter_pin_config_out
);

  reg [7:0] option_ff;
  reg [7:0] pcl_ff;
  reg [2:0] status_hi_ff;
  reg [2:0] status_lo_ff;
  reg [7:0] pointer_ff;
  reg [5:0] dir_a_ff;
  reg [7:0] dir_b_ff;
  reg [7:0] dir_c_ff;
  reg [7:0] dir_d_ff;
  reg [1:0] dir_e_hi_ff;
  reg [2:0] dir_e_lo_ff;
  reg [4:0] upper_ff;
  reg [6:0] intctl_hi_ff;
  reg intctl_lo_ff;
  reg [7:0] peripheral_irq_enable_1_ff;
  reg peripheral_irq_enable_2_ff;
  reg [1:0] cause_ff;
  reg [7:0] period_ff;
  reg [7:0] slave_addr_ff;
  reg [3:0] tx_hi_ff;
  reg [1:0] tx_lo_ff;
  reg [7:0] baud_ff;
  reg [2:0] conv_ff;
  reg [7:0] nxt_rdata;

  wire [`SEL_COUNT-1:0] sel;
  wire unmapped;
  wire self_ref;
  wire wr_go;
  wire rd_go;
  wire full_reset;

  assign wr_go = ce_in & wr_in;
  assign rd_go = ce_in & rd_in;
  assign full_reset = power_on_reset_in | brown_out_reset_in;

  sfr_addr_decode u_decode (
    .addr_in(addr_in),
    .sel_out(sel),
    .unmapped_out(unmapped)
  );

  sfr_indirect_port u_indirect (
    .ce_in(ce_in),
    .window_sel_in(sel[`SEL_WINDOW]),
    .rd_in(rd_in),
    .wr_in(wr_in),
    .wdata_in(wdata_in),
    .bank_select_in(status_hi_ff[2]),
    .pointer_in(pointer_ff),
    .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out),
    .self_ref_out(self_ref)
  );

  // Option configuration
  always @(posedge clk_in) begin
    if (reset_in) begin
      option_ff <= `RST_OPTION;
    end else if (wr_go & sel[`SEL_OPTION]) begin
      option_ff <= wdata_in;
    end
  end

  // Counter low byte; a write also loads the full counter from the buffer
  always @(posedge clk_in) begin
    if (reset_in) begin
      pcl_ff <= `RST_PCL;
      pc_load_out <= 1'b0;
      pc_load_value_out <= 13'h0000;
    end else if (ce_in) begin
      pc_load_out <= wr_in & sel[`SEL_PCL];
      if (wr_in & sel[`SEL_PCL]) begin
        pcl_ff <= wdata_in;
        pc_load_value_out <= {upper_ff, wdata_in};
      end
    end
  end

  // Status bank bits; flag bits are never reset
  always @(posedge clk_in) begin
    if (reset_in) begin
      status_hi_ff <= `RST_STATUS_HI;
    end else if (wr_go & sel[`SEL_STATUS]) begin
      status_hi_ff <= wdata_in[7:5];
    end
  end

  always @(posedge clk_in) begin
    if (~reset_in & wr_go & sel[`SEL_STATUS]) begin
      status_lo_ff <= wdata_in[2:0];
    end
  end

  // Indirect pointer, unknown at power-on and kept otherwise
  always @(posedge clk_in) begin
    if (~reset_in & wr_go & sel[`SEL_POINTER]) begin
      pointer_ff <= wdata_in;
    end
  end

  // Port directions
  always @(posedge clk_in) begin
    if (reset_in) begin
      dir_a_ff <= `RST_DIR_A;
      dir_b_ff <= `RST_DIR_B;
      dir_c_ff <= `RST_DIR_C;
      dir_d_ff <= `RST_DIR_D;
    end else if (wr_go) begin
      if (sel[`SEL_DIR_A]) begin
        dir_a_ff <= wdata_in[5:0];
      end
      if (sel[`SEL_DIR_B]) begin
        dir_b_ff <= wdata_in;
      end
      if (sel[`SEL_DIR_C]) begin
        dir_c_ff <= wdata_in;
      end
      if (sel[`SEL_DIR_D]) begin
        dir_d_ff <= wdata_in;
      end
    end
  end

  // Port E direction and slave port control; overflow set beats a write
  always @(posedge clk_in) begin
    if (reset_in) begin
      dir_e_hi_ff <= `RST_DIR_E_HI;
      dir_e_lo_ff <= `RST_DIR_E_LO;
    end else if (ce_in) begin
      if (wr_in & sel[`SEL_DIR_E]) begin
        dir_e_hi_ff[0] <= wdata_in[`DIR_E_SLAVE_MODE];
        dir_e_lo_ff <= wdata_in[2:0];
      end
      if (slave_overflow_set_in) begin
        dir_e_hi_ff[1] <= 1'b1;
      end else if (wr_in & sel[`SEL_DIR_E]) begin
        dir_e_hi_ff[1] <= wdata_in[`DIR_E_OVERFLOW];
      end
    end
  end

  // Counter upper write buffer
  always @(posedge clk_in) begin
    if (reset_in) begin
      upper_ff <= `RST_UPPER;
    end else if (wr_go & sel[`SEL_UPPER]) begin
      upper_ff <= wdata_in[4:0];
    end
  end

  // Interrupt control; lowest flag is unknown at power-on and kept otherwise
  always @(posedge clk_in) begin
    if (reset_in) begin
      intctl_hi_ff <= `RST_INTCTL_HI;
    end else if (wr_go & sel[`SEL_INTCTL]) begin
      intctl_hi_ff <= wdata_in[7:1];
    end
  end

  always @(posedge clk_in) begin
    if (~reset_in & wr_go & sel[`SEL_INTCTL]) begin
      intctl_lo_ff <= wdata_in[0];
    end
  end

  // Peripheral interrupt enables
  always @(posedge clk_in) begin
    if (reset_in) begin
      peripheral_irq_enable_1_ff <= `RST_PERIPHERAL_IRQ_ENABLE_1;
      peripheral_irq_enable_2_ff <= `RST_PERIPHERAL_IRQ_ENABLE_2;
    end else if (wr_go) begin
      if (sel[`SEL_PERIPHERAL_IRQ_ENABLE_1]) begin
        peripheral_irq_enable_1_ff <= wdata_in;
      end
      if (sel[`SEL_PERIPHERAL_IRQ_ENABLE_2]) begin
        peripheral_irq_enable_2_ff <= wdata_in[0];
      end
    end
  end

  // Reset cause: cleared by its own reset kind, unchanged by the others
  always @(posedge clk_in) begin
    if (reset_in) begin
      if (full_reset) begin
        if (power_on_reset_in) begin
          cause_ff[`CAUSE_POWER_ON] <= 1'b0;
        end
        if (brown_out_reset_in) begin
          cause_ff[`CAUSE_BROWN_OUT] <= 1'b0;
        end
      end
    end else if (wr_go & sel[`SEL_CAUSE]) begin
      cause_ff <= wdata_in[1:0];
    end
  end

  // Timer period, serial slave address, baud divisor, converter config
  always @(posedge clk_in) begin
    if (reset_in) begin
      period_ff <= `RST_PERIOD;
      slave_addr_ff <= `RST_SLAVE_ADDR;
      baud_ff <= `RST_BAUD;
      conv_ff <= `RST_CONV;
    end else if (wr_go) begin
      if (sel[`SEL_PERIOD]) begin
        period_ff <= wdata_in;
      end
      if (sel[`SEL_SLAVE_ADDR]) begin
        slave_addr_ff <= wdata_in;
      end
      if (sel[`SEL_BAUD]) begin
        baud_ff <= wdata_in;
      end
      if (sel[`SEL_CONV]) begin
        conv_ff <= wdata_in[2:0];
      end
    end
  end

  // Transmit control; shift-empty bit is read-only
  always @(posedge clk_in) begin
    if (reset_in) begin
      tx_hi_ff <= `RST_TX_HI;
      tx_lo_ff <= `RST_TX_LO;
    end else if (wr_go & sel[`SEL_TX_CTRL]) begin
      tx_hi_ff <= wdata_in[7:4];
      tx_lo_ff <= {wdata_in[2], wdata_in[0]};
    end
  end

  // Read mux
  always @* begin
    nxt_rdata = 8'h00;
    case (1'b1)
      sel[`SEL_WINDOW]: nxt_rdata = self_ref ? 8'h00 : mem_rdata_in;
      sel[`SEL_OPTION]: nxt_rdata = option_ff;
      sel[`SEL_PCL]: nxt_rdata = pcl_ff;
      sel[`SEL_STATUS]: nxt_rdata = {status_hi_ff, status_timeout_in,
                                     status_power_down_in, status_lo_ff};
      sel[`SEL_POINTER]: nxt_rdata = pointer_ff;
      sel[`SEL_DIR_A]: nxt_rdata = {2'b00, dir_a_ff};
      sel[`SEL_DIR_B]: nxt_rdata = dir_b_ff;
      sel[`SEL_DIR_C]: nxt_rdata = dir_c_ff;
      sel[`SEL_DIR_D]: nxt_rdata = dir_d_ff;
      sel[`SEL_DIR_E]: nxt_rdata = {slave_in_full_in, slave_out_full_in,
                                    dir_e_hi_ff, 1'b0, dir_e_lo_ff};
      sel[`SEL_UPPER]: nxt_rdata = {3'b000, upper_ff};
      sel[`SEL_INTCTL]: nxt_rdata = {intctl_hi_ff, intctl_lo_ff};
      sel[`SEL_PERIPHERAL_IRQ_ENABLE_1]: nxt_rdata = peripheral_irq_enable_1_ff;
      sel[`SEL_PERIPHERAL_IRQ_ENABLE_2]: nxt_rdata = {7'h00, peripheral_irq_enable_2_ff};
      sel[`SEL_CAUSE]: nxt_rdata = {6'h00, cause_ff};
      sel[`SEL_PERIOD]: nxt_rdata = period_ff;
      sel[`SEL_SLAVE_ADDR]: nxt_rdata = slave_addr_ff;
      sel[`SEL_SERIAL_FLAGS]: nxt_rdata = {2'b00, serial_port_flags_in};
      sel[`SEL_TX_CTRL]: nxt_rdata = {tx_hi_ff, 1'b0, tx_lo_ff[1],
                                      tx_shift_empty_in, tx_lo_ff[0]};
      sel[`SEL_BAUD]: nxt_rdata = baud_ff;
      sel[`SEL_CONV]: nxt_rdata = {5'h00, conv_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data stands from the cycle after the strobe until the next cycle with ce_in high
  always @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= (rd_in & ~unmapped) ? nxt_rdata : 8'h00;
    end
  end

  assign option_config_out = option_ff;
  assign counter_low_byte_out = pcl_ff;
  assign indirect_bank_select_out = status_hi_ff[2];
  assign direct_bank_select_out = status_hi_ff[1:0];
  assign alu_flags_out = status_lo_ff;
  assign indirect_pointer_out = pointer_ff;
  assign port_a_direction_out = dir_a_ff;
  assign port_b_direction_out = dir_b_ff;
  assign port_c_direction_out = dir_c_ff;
  assign port_d_direction_out = dir_d_ff;
  assign port_e_direction_out = dir_e_lo_ff;
  assign slave_port_mode_out = dir_e_hi_ff[0];
  assign slave_overflow_out = dir_e_hi_ff[1];
  assign upper_counter_buffer_out = upper_ff;
  assign interrupt_control_out = {intctl_hi_ff, intctl_lo_ff};
  assign peripheral_irq_enable_1_out = peripheral_irq_enable_1_ff;
  assign peripheral_irq_enable_2_out = peripheral_irq_enable_2_ff;
  assign power_reset_cause_out = cause_ff;
  assign timer2_period_out = period_ff;
  assign serial_slave_address_out = slave_addr_ff;
  assign uart_tx_control_out = {tx_hi_ff, tx_lo_ff};
  assign baud_divisor_out = baud_ff;
  assign converter_pin_config_out = conv_ff;

endmodule

`default_nettype wire

// ---- rtl/sfr_bank1_regs.vh ----
`ifndef SFR_BANK1_REGS_VH
`define SFR_BANK1_REGS_VH

// Register offsets
`define OFF_INDIRECT_DATA_WINDOW 8'h80
`define OFF_OPTION_CONFIG 8'h81
`define OFF_COUNTER_LOW_BYTE 8'h82
`define OFF_CORE_STATUS 8'h83
`define OFF_INDIRECT_POINTER 8'h84
`define OFF_PORT_A_DIRECTION 8'h85
`define OFF_PORT_B_DIRECTION 8'h86
`define OFF_PORT_C_DIRECTION 8'h87
`define OFF_PORT_D_DIRECTION 8'h88
`define OFF_PORT_E_DIR_AND_SLAVE_FLAGS 8'h89
`define OFF_UPPER_COUNTER_BUFFER 8'h8a
`define OFF_INTERRUPT_CONTROL 8'h8b
`define OFF_PERIPHERAL_IRQ_ENABLE_1 8'h8c
`define OFF_PERIPHERAL_IRQ_ENABLE_2 8'h8d
`define OFF_POWER_RESET_CAUSE 8'h8e
`define OFF_TIMER2_PERIOD 8'h92
`define OFF_SERIAL_SLAVE_ADDRESS 8'h93
`define OFF_SERIAL_PORT_FLAGS 8'h94
`define OFF_UART_TX_CONTROL 8'h98
`define OFF_BAUD_DIVISOR 8'h99
`define OFF_CONVERTER_PIN_CONFIG 8'h9f

// Decode select indices
`define SEL_WINDOW 0
`define SEL_OPTION 1
`define SEL_PCL 2
`define SEL_STATUS 3
`define SEL_POINTER 4
`define SEL_DIR_A 5
`define SEL_DIR_B 6
`define SEL_DIR_C 7
`define SEL_DIR_D 8
`define SEL_DIR_E 9
`define SEL_UPPER 10
`define SEL_INTCTL 11
`define SEL_PERIPHERAL_IRQ_ENABLE_1 12
`define SEL_PERIPHERAL_IRQ_ENABLE_2 13
`define SEL_CAUSE 14
`define SEL_PERIOD 15
`define SEL_SLAVE_ADDR 16
`define SEL_SERIAL_FLAGS 17
`define SEL_TX_CTRL 18
`define SEL_BAUD 19
`define SEL_CONV 20
`define SEL_COUNT 21

// Field positions
`define STATUS_INDIRECT_BANK 7
`define STATUS_TIMEOUT 4
`define STATUS_POWER_DOWN 3
`define DIR_E_IN_FULL 7
`define DIR_E_OUT_FULL 6
`define DIR_E_OVERFLOW 5
`define DIR_E_SLAVE_MODE 4
`define TX_SHIFT_EMPTY 1
`define CAUSE_POWER_ON 1
`define CAUSE_BROWN_OUT 0

// Reset values
`define RST_OPTION 8'hff
`define RST_PCL 8'h00
`define RST_STATUS_HI 3'h0
`define RST_DIR_A 6'h3f
`define RST_DIR_B 8'hff
`define RST_DIR_C 8'hff
`define RST_DIR_D 8'hff
`define RST_DIR_E_HI 2'h0
`define RST_DIR_E_LO 3'h7
`define RST_UPPER 5'h00
`define RST_INTCTL_HI 7'h00
`define RST_PERIPHERAL_IRQ_ENABLE_1 8'h00
`define RST_PERIPHERAL_IRQ_ENABLE_2 1'h0
`define RST_PERIOD 8'hff
`define RST_SLAVE_ADDR 8'h00
`define RST_TX_HI 4'h0
`define RST_TX_LO 2'h0
`define RST_BAUD 8'h00
`define RST_CONV 3'h0

`endif

// ---- rtl/sfr_addr_decode.v ----
`timescale 1ns/10ps
`default_nettype none
`include "sfr_bank1_regs.vh"

module sfr_addr_decode (
  input wire [7:0] addr_in,
  output wire [`SEL_COUNT-1:0] sel_out,
  output wire unmapped_out
);

  // Offsets in select order, entry 0 in the low byte
  localparam [`SEL_COUNT*8-1:0] OFFS = {
    `OFF_CONVERTER_PIN_CONFIG, `OFF_BAUD_DIVISOR, `OFF_UART_TX_CONTROL,
    `OFF_SERIAL_PORT_FLAGS, `OFF_SERIAL_SLAVE_ADDRESS, `OFF_TIMER2_PERIOD,
    `OFF_POWER_RESET_CAUSE, `OFF_PERIPHERAL_IRQ_ENABLE_2,
    `OFF_PERIPHERAL_IRQ_ENABLE_1, `OFF_INTERRUPT_CONTROL,
    `OFF_UPPER_COUNTER_BUFFER, `OFF_PORT_E_DIR_AND_SLAVE_FLAGS,
    `OFF_PORT_D_DIRECTION, `OFF_PORT_C_DIRECTION, `OFF_PORT_B_DIRECTION,
    `OFF_PORT_A_DIRECTION, `OFF_INDIRECT_POINTER, `OFF_CORE_STATUS,
    `OFF_COUNTER_LOW_BYTE, `OFF_OPTION_CONFIG, `OFF_INDIRECT_DATA_WINDOW};

  // Entries seen from either bank
  localparam [`SEL_COUNT-1:0] MIRROR = 21'h0_0c1d;

  genvar i;
  generate
    for (i = 0; i < `SEL_COUNT; i = i + 1) begin : g_match
      assign sel_out[i] = MIRROR[i] ?
        ({1'b0, addr_in[6:0]} == (OFFS[i*8 +: 8] & 8'h7f)) :
        (addr_in == OFFS[i*8 +: 8]);
    end
  endgenerate

  assign unmapped_out = ~|sel_out;

endmodule

`default_nettype wire

// ---- rtl/sfr_indirect_port.v ----
`timescale 1ns/10ps
`default_nettype none

module sfr_indirect_port (
  input wire ce_in,
  input wire window_sel_in,
  input wire rd_in,
  input wire wr_in,
  input wire [7:0] wdata_in,
  input wire bank_select_in,
  input wire [7:0] pointer_in,
  output wire [8:0] mem_addr_out,
  output wire mem_rd_out,
  output wire mem_wr_out,
  output wire [7:0] mem_wdata_out,
  output wire self_ref_out
);

  // Pointer aimed at the window itself reads zero and writes nothing
  assign self_ref_out = (pointer_in[6:0] == 7'h00);
  assign mem_addr_out = {bank_select_in, pointer_in};
  assign mem_rd_out = ce_in & rd_in & window_sel_in & ~self_ref_out;
  assign mem_wr_out = ce_in & wr_in & window_sel_in & ~self_ref_out;
  assign mem_wdata_out = wdata_in;

endmodule

`default_nettype wire

// ---- tb/sfr_bank1_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module sfr_bank1_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [8:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic pc_load_out,
  input wire logic [12:0] pc_load_value_out,
  input wire logic indirect_bank_select_out,
  input wire logic [7:0] indirect_pointer_out,
  input wire logic [5:0] port_a_direction_out,
  input wire logic [4:0] upper_counter_buffer_out,
  input wire logic [7:0] serial_slave_address_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic rd_ok, wr_ok, gap, win;
  assign rd_ok = rd_in && ce_in;
  assign wr_ok = wr_in && ce_in;
  assign gap = addr_in inside {[8'h8f:8'h91], [8'h95:8'h97], [8'h9a:8'h9e]};
  assign win = addr_in[6:0] == 7'h00 && indirect_pointer_out[6:0] != 7'h00;
  // Memory strobe then data returned
  sequence s_mem_req;
    mem_rd_out && mem_addr_out == {indirect_bank_select_out, indirect_pointer_out};
  endsequence
  sequence s_mem_back;
    rdata_out == $past(mem_rdata_in);
  endsequence
  property p_gap_read;
    rd_ok && gap |=> rdata_out == 8'h00;
  endproperty
  a_gap_read: assert property (p_gap_read) else $error("unmapped read not zero");
  property p_dir_a_read;
    rd_ok && addr_in == 8'h85 |=> rdata_out == {2'b00, $past(port_a_direction_out)};
  endproperty
  a_dir_a_read: assert property (p_dir_a_read) else $error("port a direction read wrong");
  property p_pc_load;
    wr_ok && addr_in[6:0] == 7'h02 |=> pc_load_out && pc_load_value_out ==
      {$past(upper_counter_buffer_out), $past(wdata_in)};
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("counter load wrong");
  property p_upper_mirror;
    wr_ok && addr_in[6:0] == 7'h0a |=> upper_counter_buffer_out == $past(wdata_in[4:0]);
  endproperty
  a_upper_mirror: assert property (p_upper_mirror) else $error("upper buffer write lost");
  property p_dir_a_reset;
    disable iff (1'b0) reset_in |=> port_a_direction_out == 6'h3f;
  endproperty
  a_dir_a_reset: assert property (p_dir_a_reset) else $error("port a direction reset wrong");
  property p_slave_reset;
    disable iff (1'b0) reset_in |=> serial_slave_address_out == 8'h00;
  endproperty
  a_slave_reset: assert property (p_slave_reset) else $error("slave address reset wrong");
  property p_win_read;
    rd_ok && win |-> s_mem_req ##1 s_mem_back;
  endproperty
  a_win_read: assert property (p_win_read) else $error("window read wrong");
  property p_win_write;
    wr_ok && win |-> mem_wr_out && !mem_rd_out && mem_wdata_out == wdata_in;
  endproperty
  a_win_write: assert property (p_win_write) else $error("window write wrong");
  property p_gap_write;
    wr_ok && gap |=> $stable(serial_slave_address_out) && $stable(port_a_direction_out)
      && $stable(upper_counter_buffer_out) && $stable(indirect_pointer_out);
  endproperty
  a_gap_write: assert property (p_gap_write) else $error("unmapped write changed state");
endmodule
bind sfr_bank1_decode sfr_bank1_checker chk_u (.clk_in, .reset_in, .ce_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .mem_rdata_in, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out, .pc_load_out,
  .pc_load_value_out, .indirect_bank_select_out, .indirect_pointer_out, .port_a_direction_out,
  .upper_counter_buffer_out, .serial_slave_address_out);
`default_nettype wire

// ---- tb/sfr_bank1_decode_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module sfr_bank1_decode_tb;
  logic clk_in = 0, reset_in = 1, ce_in = 1, por = 1, bor = 1, wr_in = 0, rd_in = 0;
  logic to_bit = 1, pd_bit = 0, ifull = 0, pc_ld, rd_pend = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, mem_rdata_in = 0, rdata_out, d, opt;
  logic [5:0] flags = 0, dir_a;
  logic [1:0] cause;
  logic [12:0] pc_val;
  integer mismatches = 0, n_tests = 0, seed = 32'h2258, cycles = 0;
  logic [7:0] exp_q[$];
  logic [7:0] ra[16] = '{8'h81, 8'h82, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d, 8'h8e, 8'h92,
    8'h93, 8'h98, 8'h99, 8'h9f};
  logic [7:0] rv[16] = '{8'hff, 8'h00, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
    8'h00, 8'h02, 8'h00, 8'h00};
  logic [7:0] ga[11] = '{8'h8f, 8'h90, 8'h91, 8'h95, 8'h96, 8'h97, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e};
  logic [7:0] ua[5] = '{8'h85, 8'h8a, 8'h8d, 8'h9f, 8'h8e};
  logic [7:0] ue[5] = '{8'h3f, 8'h1f, 8'h01, 8'h07, 8'h03};

  sfr_bank1_decode dut_u (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .power_on_reset_in(por),
    .brown_out_reset_in(bor), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .status_timeout_in(to_bit), .status_power_down_in(pd_bit),
    .slave_in_full_in(ifull), .slave_out_full_in(1'b0), .slave_overflow_set_in(1'b0),
    .serial_port_flags_in(flags), .tx_shift_empty_in(1'b1), .mem_addr_out(), .mem_rd_out(), .mem_wr_out(),
    .mem_wdata_out(), .mem_rdata_in(mem_rdata_in), .pc_load_out(pc_ld), .pc_load_value_out(pc_val),
    .option_config_out(opt), .counter_low_byte_out(), .indirect_bank_select_out(), .direct_bank_select_out(),
    .alu_flags_out(), .indirect_pointer_out(), .port_a_direction_out(dir_a), .port_b_direction_out(),
    .port_c_direction_out(), .port_d_direction_out(), .port_e_direction_out(), .slave_port_mode_out(),
    .slave_overflow_out(), .upper_counter_buffer_out(), .interrupt_control_out(),
    .peripheral_irq_enable_1_out(), .peripheral_irq_enable_2_out(), .power_reset_cause_out(cause),
    .timer2_period_out(), .serial_slave_address_out(), .uart_tx_control_out(), .baud_divisor_out(),
    .converter_pin_config_out());

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1;
    addr_in <= a;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_in <= 0;
  endtask

  task automatic rst(input logic p, input logic b);
    @(posedge clk_in);
    reset_in <= 1;
    por <= p;
    bor <= b;
    repeat (5) @(posedge clk_in);
    reset_in <= 0;
    por <= 0;
    bor <= 0;
  endtask

  // Read results checked against the oldest note
  always @(posedge clk_in) rd_pend <= rd_in && ce_in && !reset_in;
  always @(negedge clk_in) begin
    if (rd_pend) chk(rdata_out, exp_q.pop_front());
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      report_and_stop;
    end
  end

  initial begin
    d = $random(seed);
    flags <= d[5:0];
    rst(1, 1);
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(8'h94, {2'b00, flags});
    wr(8'h83, 8'h0d);
    wr(8'h84, 8'h01);
    rd(8'h83, 8'h15);
    foreach (ga[i]) begin
      d = $random(seed);
      wr(ga[i], d);
      rd(ga[i], 8'h00);
    end
    rd(8'h93, 8'h00);
    foreach (ua[i]) begin
      wr(ua[i], 8'hff);
      rd(ua[i], ue[i]);
    end
    wr(8'h9f, 8'h00);
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h00);
    rd(8'h9f, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    wr(8'h94, 8'hff);
    rd(8'h94, {2'b00, flags});
    repeat (4) begin
      d = $random(seed);
      wr(8'h93, d);
      rd(8'h93, d);
      wr(8'h0a, d);
      rd(8'h8a, {3'b000, d[4:0]});
      wr(8'h8b, d);
      rd(8'h0b, d);
      wr(8'h04, d | 8'h01);
      rd(8'h84, d | 8'h01);
      mem_rdata_in <= ~d;
      rd(8'h80, ~d);
      rd(8'h00, ~d);
      wr(8'h80, d);
    end
    rd(8'h05, 8'h00);
    wr(8'h84, 8'h80);
    rd(8'h80, 8'h00);
    wr(8'h8a, 8'h15);
    d = $random(seed);
    wr(8'h82, d);
    #1 chk(pc_ld, 1'b1);
    chk(pc_val, {5'h15, d});
    rd(8'h02, d);
    #1 chk(pc_ld, 1'b0);
    wr(8'h93, 8'h5a);
    ce_in <= 0;
    wr(8'h93, 8'ha5);
    ce_in <= 1;
    rd(8'h93, 8'h5a);
    wr(8'h85, 8'h00);
    wr(8'h8e, 8'h03);
    wr(8'h84, 8'h66);
    wr(8'h81, 8'h00);
    rst(0, 0);
    #1 chk(cause, 2'h3);
    chk(dir_a, 6'h3f);
    chk(opt, 8'hff);
    rd(8'h85, 8'h3f);
    rd(8'h93, 8'h00);
    rd(8'h84, 8'h66);
    rd(8'h8e, 8'h03);
    rd(8'h81, 8'hff);
    rst(1, 0);
    #1 chk(cause, 2'h1);
    rd(8'h8e, 8'h01);
    ifull <= 1;
    rd(8'h89, 8'h87);
    repeat (3) @(posedge clk_in);
    report_and_stop;
  end
endmodule
`default_nettype wire
